/* verilog/dac_reset_clear_flag.sv */
// Purpose: Power-up defaults, system clear and data-integrity flag for a dual DAC
// Assumes: All pins synchronous to ref_clk_in; rst_n_in is the power-on reset
// Notes:   Serial shift engine is outside; it presents decoded requests here
`timescale 1ns/1ps
`include "dac_reset_map.svh"

// Functional notes
// - At power-up every channel span field is zero, the unipolar 0 to 5 V span.
// - At power-up every DAC register is zero so each output starts at zero volts.
// - With strapped spans, the strap is applied to each updated channel on every Update.
// - A low system clear resets every DAC register to zero.
// - A system clear keeps input registers, and a later Update copies them back.
// - A clear after select/load has been low for at least one cycle aborts the serial instruction in progress.
// - The integrity flag goes low at power-up, on system clear and on brown-out.
// - The integrity flag stays low until a valid Update, then goes high.
// - After power-up or clear the readback selection points at channel A span.
// - In manual span mode the active span comes from the three strapping pins.
module dac_reset_clear_flag
    import dac_reset_pkg::*;
(
    // Clock and reset
    input  wire logic                   ref_clk_in,
    input  wire logic                   rst_n_in,
    // Host pins
    input  wire logic                   system_clear_n_in,
    input  wire logic                   load_pulse_n_in,
    input  wire logic                   select_load_n_in,
    input  wire logic                   manual_span_in,
    input  wire logic                   span_pin_2_in,
    input  wire logic                   span_pin_1_in,
    input  wire logic                   span_pin_0_in,
    // Supply monitor
    input  wire logic                   brownout_in,
    // Decoded requests from the shift engine
    input  wire write_req_t             write_req_in,
    input  wire update_req_t            update_req_in,
    input  wire logic                   rb_set_in,
    input  wire logic [`RB_SEL_W-1:0]   rb_sel_in,
    input  wire logic                   rb_chan_in,
    // Status
    output logic                        integrity_flag_n_out,
    output logic                        abort_out,
    output logic [`RB_SEL_W-1:0]        rb_sel_out,
    output logic                        rb_chan_out,
    // Active register sets
    output chan_regs_t [`NUM_CH-1:0]    dac_regs_out,
    output chan_regs_t [`NUM_CH-1:0]    input_regs_out
);

    // =====================================================
    // Decode
    function automatic logic chan_hit(input logic all, input logic chan, input int idx);
        chan_hit = all | (chan == idx[0]);
    endfunction

    logic                load_fire;
    logic                clear_now;
    logic                frame_open;
    logic                any_update;
    logic                strap_pending_reg;
    logic                strap_pending_next;
    logic [`SPAN_W-1:0]  strap_span;
    seq_state_t          state_reg;
    seq_state_t          state_next;
    chan_regs_t [`NUM_CH-1:0] dac_next;
    chan_regs_t [`NUM_CH-1:0] in_next;

    load_pulse_detect u_load
    (
        .ref_clk_in      (ref_clk_in),
        .rst_n_in        (rst_n_in),
        .load_pulse_n_in (load_pulse_n_in),
        .load_fire_out   (load_fire)
    );

    assign clear_now  = ~system_clear_n_in;
    assign frame_open = ~select_load_n_in;
    // Clear suppresses updates in the same cycle
    assign any_update = ~clear_now & ((update_req_in.valid & frame_open) | load_fire);
    assign strap_span = {1'b0, span_pin_2_in, span_pin_1_in, span_pin_0_in};
    assign strap_pending_next = any_update ? 1'b0 : strap_pending_reg;

    // =====================================================
    // Sequencer state
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            ST_POWERUP: state_next = ST_IDLE;
            ST_IDLE:    if (frame_open && !clear_now) state_next = ST_FRAME;
            ST_FRAME:   if (clear_now || !frame_open) state_next = ST_IDLE;
            default:    state_next = ST_IDLE;
        endcase
    end

    // =====================================================
    // Register next values
    genvar g;
    generate
        for (g = 0; g < `NUM_CH; g++)
        begin : g_ch
            wire hit_wr = write_req_in.valid & frame_open & ~clear_now
                        & chan_hit(write_req_in.all, write_req_in.chan, g);
            wire hit_up = any_update
                        & (load_fire | chan_hit(update_req_in.all, update_req_in.chan, g));
            wire [`SPAN_W-1:0] up_span = (manual_span_in && strap_pending_reg)
                        ? strap_span : input_regs_out[g].span;
            assign in_next[g].span = (hit_wr && write_req_in.is_span)
                        ? write_req_in.data[`SPAN_W-1:0] : input_regs_out[g].span;
            assign in_next[g].code = (hit_wr && !write_req_in.is_span)
                        ? write_req_in.data : input_regs_out[g].code;
            assign dac_next[g].span = clear_now ? `SPAN_RESET
                        : (hit_up ? (manual_span_in ? strap_span : up_span)
                                  : dac_regs_out[g].span);
            assign dac_next[g].code = clear_now ? `CODE_RESET
                        : (hit_up ? input_regs_out[g].code : dac_regs_out[g].code);
        end
    endgenerate

    // =====================================================
    // Registers
    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state_reg            <= ST_POWERUP;
            strap_pending_reg    <= 1'b1;
            integrity_flag_n_out <= 1'b0;
            abort_out            <= 1'b0;
            rb_sel_out           <= `RB_DAC_SPAN_A;
            rb_chan_out          <= 1'b0;
            dac_regs_out         <= '0;
            input_regs_out       <= '0;
        end
        else
        begin
            state_reg         <= state_next;
            strap_pending_reg <= strap_pending_next;
            dac_regs_out      <= dac_next;
            input_regs_out    <= in_next;
            abort_out         <= clear_now && state_reg == ST_FRAME;
            if (clear_now || brownout_in)
                integrity_flag_n_out <= 1'b0;
            else if (any_update)
                integrity_flag_n_out <= 1'b1;
            if (clear_now)
            begin
                rb_sel_out  <= `RB_DAC_SPAN_A;
                rb_chan_out <= 1'b0;
            end
            else if (rb_set_in && frame_open)
            begin
                rb_sel_out  <= rb_sel_in;
                rb_chan_out <= rb_chan_in;
            end
        end
    end

    // =====================================================
    // Checks
    sequence s_clear;
        !system_clear_n_in;
    endsequence

    property p_clear_zero;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        s_clear |=> dac_regs_out[0].code == 16'h0000 && dac_regs_out[1].code == 16'h0000;
    endproperty
    a_clear_zero: assert property (p_clear_zero) else $error("dac not zero after clear");

    property p_clear_keeps_input;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        s_clear |=> input_regs_out == $past(input_regs_out);
    endproperty
    a_clear_keeps_input: assert property (p_clear_keeps_input)
        else $error("input regs changed on clear");

    property p_flag_low;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (s_clear or brownout_in) |=> !integrity_flag_n_out;
    endproperty
    a_flag_low: assert property (p_flag_low) else $error("flag not low");

    property p_flag_release;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (any_update && !brownout_in) |=> integrity_flag_n_out;
    endproperty
    a_flag_release: assert property (p_flag_release) else $error("flag not released");

    property p_flag_hold;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (!integrity_flag_n_out && !any_update) |=> !integrity_flag_n_out;
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag released early");

    property p_rb_reset;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        s_clear |=> rb_sel_out == `RB_DAC_SPAN_A && !rb_chan_out;
    endproperty
    a_rb_reset: assert property (p_rb_reset) else $error("readback not at span A");

    property p_abort;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        ((state_reg == ST_FRAME) and s_clear) |=> abort_out && state_reg == ST_IDLE;
    endproperty
    a_abort: assert property (p_abort) else $error("frame not aborted");

    property p_load_update;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        ($fell(load_pulse_n_in) && system_clear_n_in) ##1 (system_clear_n_in && !brownout_in)
            |=> integrity_flag_n_out && dac_regs_out[1].code == $past(input_regs_out[1].code);
    endproperty
    a_load_update: assert property (p_load_update) else $error("load pulse ignored");

    property p_strap_once;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (any_update && manual_span_in
            && (load_fire || update_req_in.all || !update_req_in.chan))
            |=> !strap_pending_reg
            && dac_regs_out[0].span == $past(strap_span);
    endproperty
    a_strap_once: assert property (p_strap_once) else $error("strap span not applied");

    property p_powerup_zero;
        @(posedge ref_clk_in) $rose(rst_n_in) |-> dac_regs_out[0].span == 4'h0
            && dac_regs_out[1] == '0 && dac_regs_out[0].code == 16'h0000;
    endproperty
    a_powerup_zero: assert property (p_powerup_zero) else $error("bad power-up");

endmodule

/* common/dac_reset_map.svh */
// Purpose: Field widths, reset values, readback encodings and timing counts for the clear block
// Assumes: 100 MHz reference clock
// Notes:   Definitions only
`ifndef DAC_RESET_MAP_SVH
`define DAC_RESET_MAP_SVH

// =====================================================
// Field widths and reset values
`define SPAN_W            4
`define CODE_W            16
`define NUM_CH            2
`define SPAN_RESET        4'h0
`define CODE_RESET        16'h0000
// =====================================================
// Readback selector encodings
`define RB_SEL_W          3
`define RB_DAC_SPAN_A     3'h0
`define RB_DAC_CODE       3'h1
`define RB_IN_SPAN        3'h2
`define RB_IN_CODE        3'h3
// =====================================================
// Load pin filter length in cycles
`define LOAD_STABLE_CYC   2'h1

`endif

/* common/dac_reset_pkg.sv */
// Purpose: Types shared by the clear block files
// Assumes: Map header included first
// Notes:   Types only
`include "dac_reset_map.svh"

package dac_reset_pkg;

    // =====================================================
    // Per-channel register set
    typedef struct packed
    {
        logic [`SPAN_W-1:0] span;
        logic [`CODE_W-1:0] code;
    } chan_regs_t;

    // Update request from the command decoder
    typedef struct packed
    {
        logic       valid;
        logic       all;
        logic       chan;
    } update_req_t;

    // Input register write request
    typedef struct packed
    {
        logic               valid;
        logic               all;
        logic               chan;
        logic               is_span;
        logic [`CODE_W-1:0] data;
    } write_req_t;

    typedef enum logic [1:0]
    {
        ST_POWERUP = 2'b00,
        ST_IDLE    = 2'b01,
        ST_FRAME   = 2'b10
    } seq_state_t;

endpackage

/* verilog/load_pulse_detect.sv */
// Purpose: Falling-edge detect on the active-low load pulse pin
// Assumes: Pin synchronous to the reference clock
// Notes:   One-cycle pulse per falling edge
`timescale 1ns/1ps

module load_pulse_detect
(
    // Clock and reset
    input  wire logic ref_clk_in,
    input  wire logic rst_n_in,
    // Pin and pulse
    input  wire logic load_pulse_n_in,
    output logic      load_fire_out
);

    logic load_prev_reg;

    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            load_prev_reg <= 1'b1;
            load_fire_out <= 1'b0;
        end
        else
        begin
            load_prev_reg <= load_pulse_n_in;
            load_fire_out <= load_prev_reg & ~load_pulse_n_in;
        end
    end

endmodule

/* test/host_drive.sv */
// Purpose: Host model for the clear, load and select pins
// Assumes: Pins change just after a rising edge
// Notes:   Released request data shows inverted bits
`timescale 1ns/1ps
`include "dac_reset_map.svh"

module host_drive
    import dac_reset_pkg::*;
(
    // Clock
    input  wire logic            ref_clk_in,
    // Host pins
    output logic                 system_clear_n_out,
    output logic                 load_pulse_n_out,
    output logic                 select_load_n_out,
    // Decoded requests
    output write_req_t           write_req_out,
    output update_req_t          update_req_out,
    output logic                 rb_set_out,
    output logic [`RB_SEL_W-1:0] rb_sel_out,
    output logic                 rb_chan_out
);
    initial
    begin
        system_clear_n_out = 1'b1;
        load_pulse_n_out   = 1'b1;
        select_load_n_out  = 1'b1;
        write_req_out      = '0;
        update_req_out     = '0;
        rb_set_out         = 1'b0;
        rb_sel_out         = '0;
        rb_chan_out        = 1'b0;
    end

    // =====================================================
    // Framed write, pointer load, then update
    task automatic instr(input write_req_t w, input update_req_t u, input logic [3:0] rb);
        @(posedge ref_clk_in);
        select_load_n_out         <= 1'b0;
        write_req_out             <= w;
        rb_set_out                <= 1'b1;
        {rb_sel_out, rb_chan_out} <= rb;
        @(posedge ref_clk_in);
        write_req_out             <= {1'b0, ~w[18:0]};
        rb_set_out                <= 1'b0;
        update_req_out            <= u;
        @(posedge ref_clk_in);
        update_req_out            <= '0;
        select_load_n_out         <= 1'b1;
    endtask

    // =====================================================
    // One-cycle clear, optionally inside an open frame
    task automatic clear(input logic in_frame);
        @(posedge ref_clk_in);
        select_load_n_out  <= ~in_frame;
        if (in_frame)
        begin
            repeat (2) @(posedge ref_clk_in);
        end
        system_clear_n_out <= 1'b0;
        @(posedge ref_clk_in);
        system_clear_n_out <= 1'b1;
        select_load_n_out  <= 1'b1;
    endtask

    // =====================================================
    // Load pin low for three cycles
    task automatic load();
        @(posedge ref_clk_in);
        load_pulse_n_out <= 1'b0;
        repeat (3) @(posedge ref_clk_in);
        load_pulse_n_out <= 1'b1;
    endtask
endmodule

/* test/dac_reset_clear_flag_test.sv */
// Purpose: Self-checking bench for power-up, clear and integrity flag
// Assumes: 100 MHz clock; reset held 12 cycles
// Notes:   Host pins come from the host model
`timescale 1ns/1ps
`include "dac_reset_map.svh"

module dac_reset_clear_flag_test
    import dac_reset_pkg::*;
;
    logic                        ref_clk, rst_n, clear_n, load_n, select_n;
    logic                        manual, brownout, rb_set, rb_chan, flag_n, abort, rb_chan_q;
    logic [2:0]                  strap;
    logic [`RB_SEL_W-1:0]        rb_sel_h, rb_sel;
    write_req_t                  wr;
    update_req_t                 up;
    chan_regs_t [`NUM_CH-1:0]    dac, inp;
    int                          bad_count = 0;
    int                          n_compared = 0;
    int                          abort_seen = 0;

    host_drive u_host_drive (.ref_clk_in(ref_clk), .system_clear_n_out(clear_n),
        .load_pulse_n_out(load_n), .select_load_n_out(select_n), .write_req_out(wr),
        .update_req_out(up), .rb_set_out(rb_set), .rb_sel_out(rb_sel_h), .rb_chan_out(rb_chan));

    dac_reset_clear_flag u_dac_reset_clear_flag (.ref_clk_in(ref_clk), .rst_n_in(rst_n),
        .system_clear_n_in(clear_n), .load_pulse_n_in(load_n), .select_load_n_in(select_n),
        .manual_span_in(manual), .span_pin_2_in(strap[2]), .span_pin_1_in(strap[1]),
        .span_pin_0_in(strap[0]), .brownout_in(brownout), .write_req_in(wr),
        .update_req_in(up), .rb_set_in(rb_set), .rb_sel_in(rb_sel_h), .rb_chan_in(rb_chan),
        .integrity_flag_n_out(flag_n), .abort_out(abort), .rb_sel_out(rb_sel),
        .rb_chan_out(rb_chan_q), .dac_regs_out(dac), .input_regs_out(inp));

    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk)
    begin
        if (abort === 1'b1)
            abort_seen++;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("Compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // =====================================================
    // Scenarios
    task automatic t_reset();
        check({dac[1].span, dac[0].span}, 32'h0);
        check({dac[1].code, dac[0].code}, 32'h0);
        check(flag_n, 32'h0);
        check({rb_sel, rb_chan_q}, 32'h0);
    endtask

    task automatic t_update();
        u_host_drive.instr('{1'b1, 1'b0, 1'b0, 1'b0, 16'h1234}, '{1'b1, 1'b0, 1'b0}, 4'h7);
        #1;
        check({dac[1].code, dac[0].code}, 32'h1234);
        check(flag_n, 32'h1);
        u_host_drive.instr('{1'b1, 1'b0, 1'b1, 1'b0, 16'hbeef}, '0, 4'h7);
        #1;
        check({rb_sel, rb_chan_q}, 32'h7);
        u_host_drive.instr('{1'b1, 1'b1, 1'b0, 1'b1, 16'h0003}, '{1'b1, 1'b1, 1'b0}, 4'h4);
        #1;
        check({dac[1].span, dac[0].span}, 32'h33);
        check({inp[1].span, inp[0].span}, 32'h33);
        check({rb_sel, rb_chan_q}, 32'h4);
    endtask

    task automatic t_clear();
        abort_seen = 0;
        u_host_drive.clear(1'b0);
        #1;
        check({dac[1].code, dac[0].code}, 32'h0);
        check(flag_n, 32'h0);
        check({inp[1].code, inp[0].code}, 32'hbeef1234);
        check({inp[1].span, inp[0].span}, 32'h33);
        check({dac[1].span, dac[0].span}, 32'h0);
        check({rb_sel, rb_chan_q}, 32'h0);
        repeat (3) @(posedge ref_clk);
        #1;
        check(abort_seen, 32'h0);
    endtask

    task automatic t_load();
        u_host_drive.load();
        #1;
        check({dac[1].code, dac[0].code}, 32'hbeef1234);
        check({dac[1].span, dac[0].span}, 32'h33);
        check(flag_n, 32'h1);
    endtask

    task automatic t_abort();
        abort_seen = 0;
        u_host_drive.clear(1'b1);
        repeat (3) @(posedge ref_clk);
        #1;
        check(abort_seen, 32'h1);
        check(dac[0].code, 32'h0);
        // Write and update channel A, whose DAC register the abort cleared
        u_host_drive.instr('{1'b1, 1'b0, 1'b0, 1'b0, 16'h0042}, '{1'b1, 1'b0, 1'b0}, 4'h0);
        #1;
        check(dac[0].code, 32'h42);
    endtask

    task automatic t_strap();
        @(posedge ref_clk);
        brownout <= 1'b1;
        manual   <= 1'b1;
        strap    <= 3'b101;
        @(posedge ref_clk);
        brownout <= 1'b0;
        #1;
        check(flag_n, 32'h0);
        check({dac[1].span, dac[0].span}, 32'h03);
        u_host_drive.instr('0, '{1'b1, 1'b1, 1'b0}, 4'h0);
        #1;
        check({dac[1].span, dac[0].span}, 32'h55);
        check(flag_n, 32'h1);
    endtask

    initial
    begin
        rst_n    = 1'b0;
        manual   = 1'b0;
        brownout = 1'b0;
        strap    = 3'b000;
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        #1;
        t_reset();
        t_update();
        t_clear();
        t_load();
        t_abort();
        t_strap();
        @(posedge ref_clk);
        rst_n <= 1'b0;
        @(posedge ref_clk);
        rst_n <= 1'b1;
        #1;
        t_reset();
        conclude();
    end

    initial
    begin
        repeat (2000) @(posedge ref_clk);
        bad_count++;
        conclude();
    end
endmodule
